// file: ddr2_cmd_state.sv
// Contract
// - Refresh with CKE low enters self refresh; only with all banks idle, else flagged illegal.
// - CKE low with NOP enters power-down.
// - Idle means precharge power-down, DLL off; open rows keep the DLL only if fast.
// - CKE high with NOP exits; wait exit latency.
// - Decode command from strobes, CKE pair, A10.
// - Bank bits pick bank or mode register.
// - Self refresh exits when CKE returns high with a NOP or deselect.
//
// Command decoder and power state tracker of one DDR2 device.
// Assumes the command pins are synchronous to CORE_CLK.
`timescale 1ns/1ps
`include "ddr2_cmd_consts.svh"
module ddr2_cmd_state #(
  parameter int RP = `RP_CLKS,
  parameter int XP = `XP_CLKS,
  parameter bit SLOW_EXIT = 1'b0
) (
  input wire logic CORE_CLK,
  input wire logic RST_B,
  input wire ddr2_cmd_pkg::pins_s PINS,
  output ddr2_cmd_pkg::pstate_e PSTATE,
  output logic DLL_ON,
  output logic BUFS_ON,
  output logic [`NUM_BANKS-1:0] BANK_OPEN,
  output logic [`BANK_W-1:0] MR_SEL,
  output logic MR_WR,
  output logic AUTO_PRE,
  output logic CMD_READY,
  output logic CMD_ILLEGAL
);
  // ===========================================================
  // Previous clock-enable sample.
  logic cke_prev_q;
  // Decoded command of this edge.
  ddr2_cmd_pkg::cmd_e cmd;
  // Per-bank strobes and status.
  logic [`NUM_BANKS-1:0] act_v, pre_v, open_v, busy_v;
  logic all_idle;
  logic sel_nop;
  assign all_idle = (open_v == '0) && (busy_v == '0);
  assign sel_nop = PINS.cs_b || (PINS.ras_b && PINS.cas_b && PINS.we_b);
  // ===========================================================
  // Command decode from strobes and the two clock-enable samples.
  always_comb begin
    cmd = ddr2_cmd_pkg::CMD_ILL;
    if (!cke_prev_q) begin
      if (!PINS.cke) begin
        cmd = ddr2_cmd_pkg::CMD_HOLD;
      end else if (sel_nop) begin
        cmd = ddr2_cmd_pkg::CMD_EXIT;
      end
    end else if (!PINS.cke) begin
      if (sel_nop) begin
        cmd = ddr2_cmd_pkg::CMD_PD_IN;
      end else if (!PINS.ras_b && !PINS.cas_b && PINS.we_b) begin
        cmd = ddr2_cmd_pkg::CMD_SREF_IN;
      end
    end else if (sel_nop) begin
      cmd = ddr2_cmd_pkg::CMD_NOP;
    end else begin
      unique case ({PINS.ras_b, PINS.cas_b, PINS.we_b})
        3'h3: cmd = ddr2_cmd_pkg::CMD_ACT;
        3'h2: cmd = PINS.addr[`AP_BIT] ? ddr2_cmd_pkg::CMD_PREA : ddr2_cmd_pkg::CMD_PRE;
        3'h5: cmd = ddr2_cmd_pkg::CMD_RD;
        3'h4: cmd = ddr2_cmd_pkg::CMD_WR;
        3'h1: cmd = ddr2_cmd_pkg::CMD_REF;
        3'h0: cmd = ddr2_cmd_pkg::CMD_MRS;
        default: cmd = ddr2_cmd_pkg::CMD_NOP;
      endcase
    end
  end
  // ===========================================================
  // Bank strobes: bank bits choose the target bank.
  always_comb begin
    act_v = '0;
    pre_v = '0;
    if (cmd == ddr2_cmd_pkg::CMD_ACT) begin
      act_v[PINS.ba] = 1'b1;
    end
    if (cmd == ddr2_cmd_pkg::CMD_PRE) begin
      pre_v[PINS.ba] = 1'b1;
    end
  end
  // One timer per bank.
  for (genvar b = 0; b < `NUM_BANKS; b++) begin : g_bank
    ddr2_bank_timer #(.RP(RP)) u_timer (
      .clk(CORE_CLK),
      .rst_b(RST_B),
      .act(act_v[b]),
      .pre(pre_v[b]),
      .pre_all(cmd == ddr2_cmd_pkg::CMD_PREA),
      .open_q(open_v[b]),
      .busy_q(busy_v[b])
    );
  end
  // ===========================================================
  // Power state machine and output registers.
  ddr2_cmd_pkg::pstate_e st_q, st_d;
  logic [7:0] xcnt_q, xcnt_d;
  logic dll_d, bufs_d, mrwr_d, ap_d, ill_d, rdy_d;
  logic [`BANK_W-1:0] mrsel_d;
  always_comb begin
    st_d = st_q;
    xcnt_d = (xcnt_q != 8'h00) ? xcnt_q - 8'h01 : 8'h00;
    mrsel_d = MR_SEL;
    mrwr_d = 1'b0;
    ap_d = 1'b0;
    ill_d = (cmd == ddr2_cmd_pkg::CMD_ILL);
    unique case (st_q)
      ddr2_cmd_pkg::ST_RUN, ddr2_cmd_pkg::ST_EXIT: begin
        if (st_q == ddr2_cmd_pkg::ST_EXIT && xcnt_q == 8'h00) begin
          st_d = ddr2_cmd_pkg::ST_RUN;
        end
        if (cmd == ddr2_cmd_pkg::CMD_PD_IN) begin
          // Idle banks give precharge power-down, open rows active.
          if (all_idle) begin
            st_d = ddr2_cmd_pkg::ST_PPD;
          end else begin
            st_d = SLOW_EXIT ? ddr2_cmd_pkg::ST_APD_SLOW : ddr2_cmd_pkg::ST_APD_FAST;
          end
        end else if (cmd == ddr2_cmd_pkg::CMD_SREF_IN) begin
          // Self refresh only from all banks idle; otherwise flag the request and stay.
          if (all_idle) begin
            st_d = ddr2_cmd_pkg::ST_SREF;
          end else begin
            ill_d = 1'b1;
          end
        end else if (cmd == ddr2_cmd_pkg::CMD_MRS) begin
          mrsel_d = PINS.ba;
          mrwr_d = 1'b1;
        end else if (cmd == ddr2_cmd_pkg::CMD_RD || cmd == ddr2_cmd_pkg::CMD_WR) begin
          ap_d = PINS.addr[`AP_BIT];
        end
      end
      default: begin
        // Any power-down or self refresh leaves only on exit.
        if (cmd == ddr2_cmd_pkg::CMD_EXIT) begin
          st_d = ddr2_cmd_pkg::ST_EXIT;
          // The exit state itself is the first clock, so the count starts one short.
          xcnt_d = 8'(XP - 1);
        end
      end
    endcase
    dll_d = (st_d == ddr2_cmd_pkg::ST_RUN) || (st_d == ddr2_cmd_pkg::ST_EXIT)
      || (st_d == ddr2_cmd_pkg::ST_APD_FAST);
    bufs_d = (st_d == ddr2_cmd_pkg::ST_RUN) || (st_d == ddr2_cmd_pkg::ST_EXIT);
    rdy_d = (st_d == ddr2_cmd_pkg::ST_RUN);
  end
  always_ff @(posedge CORE_CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_q <= ddr2_cmd_pkg::ST_RUN;
      xcnt_q <= 8'h00;
      cke_prev_q <= 1'b1;
      PSTATE <= ddr2_cmd_pkg::ST_RUN;
      DLL_ON <= 1'b1;
      BUFS_ON <= 1'b1;
      BANK_OPEN <= '0;
      MR_SEL <= '0;
      MR_WR <= 1'b0;
      AUTO_PRE <= 1'b0;
      CMD_READY <= 1'b1;
      CMD_ILLEGAL <= 1'b0;
    end else begin
      st_q <= st_d;
      xcnt_q <= xcnt_d;
      cke_prev_q <= PINS.cke;
      PSTATE <= st_d;
      DLL_ON <= dll_d;
      BUFS_ON <= bufs_d;
      BANK_OPEN <= open_v;
      MR_SEL <= mrsel_d;
      MR_WR <= mrwr_d;
      AUTO_PRE <= ap_d;
      CMD_READY <= rdy_d;
      CMD_ILLEGAL <= ill_d;
    end
  end
  // ===========================================================
  // Checks and covers.
  chk_pd_entry: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_q == ddr2_cmd_pkg::ST_RUN && cmd == ddr2_cmd_pkg::CMD_PD_IN) |=> !BUFS_ON)
    else $error("power-down entry missed");
  chk_ppd_dll: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_q == ddr2_cmd_pkg::ST_RUN && cmd == ddr2_cmd_pkg::CMD_PD_IN && all_idle) |=>
    PSTATE == ddr2_cmd_pkg::ST_PPD && !DLL_ON) else $error("precharge power-down wrong");
  // Active power-down keeps the DLL running only in the fast-exit build.
  chk_apd_dll: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_q == ddr2_cmd_pkg::ST_RUN && cmd == ddr2_cmd_pkg::CMD_PD_IN && !all_idle) |=>
    DLL_ON == !SLOW_EXIT && !BUFS_ON) else $error("active power-down dll wrong");
  chk_sref_entry: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_q == ddr2_cmd_pkg::ST_RUN && cmd == ddr2_cmd_pkg::CMD_SREF_IN && all_idle) |=>
    PSTATE == ddr2_cmd_pkg::ST_SREF && !BUFS_ON) else $error("self refresh entry wrong");
  // A self refresh request with a bank open or precharging is flagged and dropped.
  chk_sref_refused: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_q == ddr2_cmd_pkg::ST_RUN && cmd == ddr2_cmd_pkg::CMD_SREF_IN && !all_idle) |=>
    PSTATE == ddr2_cmd_pkg::ST_RUN && CMD_ILLEGAL) else $error("self refresh not refused");
  chk_exit_wait: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_q != ddr2_cmd_pkg::ST_RUN && st_q != ddr2_cmd_pkg::ST_EXIT
    && cmd == ddr2_cmd_pkg::CMD_EXIT) |=> !CMD_READY ##1 !CMD_READY ##1 CMD_READY)
    else $error("exit latency wrong");
  chk_sref_hold: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_q == ddr2_cmd_pkg::ST_SREF && !PINS.cke) |=> PSTATE == ddr2_cmd_pkg::ST_SREF)
    else $error("self refresh left early");
  chk_mr_select: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_q == ddr2_cmd_pkg::ST_RUN && cmd == ddr2_cmd_pkg::CMD_MRS) |=>
    MR_WR && MR_SEL == $past(PINS.ba)) else $error("mode register select wrong");
  chk_ap_flag: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (st_q == ddr2_cmd_pkg::ST_RUN && cmd == ddr2_cmd_pkg::CMD_RD) |=>
    AUTO_PRE == $past(PINS.addr[`AP_BIT])) else $error("auto-precharge flag wrong");
  chk_act_open: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (cmd == ddr2_cmd_pkg::CMD_ACT) |=> ##1 BANK_OPEN[$past(PINS.ba, 2)])
    else $error("bank not opened");
  cov_ppd: cover property (@(posedge CORE_CLK) PSTATE == ddr2_cmd_pkg::ST_PPD);
  cov_apd: cover property (@(posedge CORE_CLK) PSTATE == ddr2_cmd_pkg::ST_APD_FAST);
  cov_sref: cover property (@(posedge CORE_CLK) PSTATE == ddr2_cmd_pkg::ST_SREF);
  cov_exit: cover property (@(posedge CORE_CLK) PSTATE == ddr2_cmd_pkg::ST_EXIT);
endmodule : ddr2_cmd_state

// file: ddr2_cmd_consts.svh
// Timing counts and field positions for the command-level power state block.
// Included by the package and the design modules; definitions only.
`ifndef DDR2_CMD_CONSTS_SVH
`define DDR2_CMD_CONSTS_SVH
// Number of banks and bank address width.
`define NUM_BANKS 8
`define BANK_W 3
// Address bit that selects auto-precharge or all-bank precharge.
`define AP_BIT 10
// Address bus width.
`define ADDR_W 14
// Clock-enable minimum registration, in clocks.
`define CKE_MIN_CLKS 3
// Power-down exit latency, in clocks.
`define XP_CLKS 2
// Precharge period in clocks; all-bank precharge adds one clock.
`define RP_CLKS 4
`define RP_EXTRA_ALL 1
`endif

// file: ddr2_cmd_pkg.sv
// Types shared by the command decoder, the controller model and the testbench.
// Assumes ddr2_cmd_consts.svh is on the include path.
`include "ddr2_cmd_consts.svh"
package ddr2_cmd_pkg;
  // ===========================================================
  // Decoded commands.
  typedef enum logic [3:0] {
    CMD_NOP, CMD_ACT, CMD_RD, CMD_WR, CMD_PRE, CMD_PREA, CMD_REF,
    CMD_SREF_IN, CMD_MRS, CMD_PD_IN, CMD_EXIT, CMD_HOLD, CMD_ILL
  } cmd_e;
  // Device power states.
  typedef enum logic [2:0] {
    ST_RUN, ST_PPD, ST_APD_FAST, ST_APD_SLOW, ST_SREF, ST_EXIT
  } pstate_e;
  // Command pins sampled at the rising edge.
  typedef struct packed {
    logic cs_b;
    logic ras_b;
    logic cas_b;
    logic we_b;
    logic cke;
    logic [`BANK_W-1:0] ba;
    logic [`ADDR_W-1:0] addr;
  } pins_s;
endpackage : ddr2_cmd_pkg

// file: ddr2_bank_timer.sv
// One bank's open flag and precharge period counter.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`include "ddr2_cmd_consts.svh"
module ddr2_bank_timer #(
  parameter int RP = `RP_CLKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic act,
  input wire logic pre,
  input wire logic pre_all,
  output logic open_q,
  output logic busy_q
);
  // Counter wide enough for the precharge period plus one.
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic open_d;
  // ===========================================================
  // Next state: latest precharge restarts the period.
  always_comb begin
    open_d = open_q;
    cnt_d = (cnt_q != 8'h00) ? cnt_q - 8'h01 : 8'h00;
    if (act) begin
      open_d = 1'b1;
    end
    if (pre_all) begin
      open_d = 1'b0;
      cnt_d = 8'(RP + `RP_EXTRA_ALL);
    end else if (pre) begin
      open_d = 1'b0;
      cnt_d = 8'(RP);
    end
  end
  // Registers.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      open_q <= 1'b0;
      cnt_q <= 8'h00;
    end else begin
      open_q <= open_d;
      cnt_q <= cnt_d;
    end
  end
  assign busy_q = (cnt_q != 8'h00);
  chk_prea_period: assert property (@(posedge clk) disable iff (!rst_b)
    pre_all |=> cnt_q == 8'(RP + `RP_EXTRA_ALL)) else $error("all-bank period wrong");
  chk_pre_closes: assert property (@(posedge clk) disable iff (!rst_b)
    (pre || pre_all) |=> !open_q) else $error("bank not closed");
endmodule : ddr2_bank_timer

// file: ddr2_ctrl_model.sv
// Behavioural memory controller that drives the command pins of the device.
// Assumes one clock; the testbench calls its tasks hierarchically.
`timescale 1ns/1ps
`include "ddr2_cmd_consts.svh"
module ddr2_ctrl_model (
  input wire logic clk,
  output ddr2_cmd_pkg::pins_s pins
);
  // ==========================================================
  // Idle state
  // Pins start as a NOP with clock enable high.
  initial begin
    pins = {4'h7, 1'b1, 3'h0, 14'h0000};
  end

  // Spacing the controller keeps before precharging a bank, in clocks.
  // Read: half burst plus the rounded-up read-to-precharge count, less two.
  localparam int RD_PRE_GAP = 2;
  // Write: write latency plus half burst plus write recovery.
  localparam int WR_PRE_GAP = 8;

  // ==========================================================
  // Command issue
  // One command per clock, changed at the falling edge and held until the next one.
  // Strobes are packed as cs, ras, cas, we.
  task automatic send(input logic [3:0] s, input logic k, input logic [`BANK_W-1:0] b,
                      input logic [`ADDR_W-1:0] a);
    @(negedge clk);
    pins = {s, k, b, a};
    @(posedge clk);
    #1;
  endtask : send

  // Issues NOPs with clock enable held; used for spacing and cke hold time.
  task automatic idle(input int n);
    logic k;
    k = pins.cke;
    for (int i = 0; i < n; i++) begin
      send(4'h7, k, 3'h0, 14'h0000);
    end
  endtask : idle
endmodule : ddr2_ctrl_model

// file: ddr2_precharge_refresh_powerdown_tb_top.sv
// Self-checking testbench of the command decoder and power state tracker.
// Assumes the controller model drives PINS and the main build uses default parameters.
`timescale 1ns/1ps
`include "ddr2_cmd_consts.svh"
module ddr2_precharge_refresh_powerdown_tb_top;
  logic core_clk = 1'b0; // 10 MHz clock.
  logic rst_b = 1'b0; // Active-low reset.
  ddr2_cmd_pkg::pins_s pins;
  ddr2_cmd_pkg::pstate_e pstate;
  logic dll_on, bufs_on, mr_wr, auto_pre, cmd_ready, cmd_illegal;
  logic [`NUM_BANKS-1:0] bank_open;
  logic [`BANK_W-1:0] mr_sel;
  ddr2_cmd_pkg::pstate_e pstate_slow; // State of the slow-exit build.
  logic dll_slow; // DLL flag of the slow-exit build.
  int failures = 0;
  int tests_run = 0;

  // ==========================================================
  // Clock, design and controller
  initial begin
    forever #50 core_clk = ~core_clk;
  end
  ddr2_cmd_state dut_u (.CORE_CLK(core_clk), .RST_B(rst_b), .PINS(pins), .PSTATE(pstate),
    .DLL_ON(dll_on), .BUFS_ON(bufs_on), .BANK_OPEN(bank_open), .MR_SEL(mr_sel),
    .MR_WR(mr_wr), .AUTO_PRE(auto_pre), .CMD_READY(cmd_ready), .CMD_ILLEGAL(cmd_illegal));
  // Second build with slow-exit active power-down, fed the same pins.
  ddr2_cmd_state #(.SLOW_EXIT(1'b1)) dut_slow_u (.CORE_CLK(core_clk), .RST_B(rst_b),
    .PINS(pins), .PSTATE(pstate_slow), .DLL_ON(dll_slow), .BUFS_ON(), .BANK_OPEN(),
    .MR_SEL(), .MR_WR(), .AUTO_PRE(), .CMD_READY(), .CMD_ILLEGAL());
  ddr2_ctrl_model model_u (.clk(core_clk), .pins(pins));

  // ==========================================================
  // Shared helpers
  // Compares with case equality so an unknown never matches.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t %s", $time, what);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("comparisons=%0d mismatches=%0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict

  // Holds reset for 16 clocks with the pins idle, then checks reset values.
  task automatic do_reset();
    @(negedge core_clk);
    rst_b = 1'b0;
    // Park the pins as a NOP with clock enable high, so release is no power-down entry.
    model_u.send(4'h7, 1'b1, 3'h0, 14'h0000);
    repeat (15) @(negedge core_clk);
    rst_b = 1'b1;
    @(posedge core_clk);
    #1;
    check(pstate, ddr2_cmd_pkg::ST_RUN, "reset state");
    check({dll_on, bufs_on, cmd_ready, mr_wr, auto_pre, cmd_illegal}, 6'h38, "reset flags");
    check(bank_open, 8'h00, "reset banks");
    $display("test reset done");
  endtask : do_reset

  // Waits a bounded time for the run state and checks the exit latency.
  task automatic wait_run();
    int n;
    n = 0;
    while (pstate !== ddr2_cmd_pkg::ST_RUN) begin
      if (n == 8) begin
        failures++;
        $display("[FAIL] t=%0t no return to run", $time);
        print_verdict();
      end
      model_u.idle(1);
      n++;
    end
    check(16'(n), 16'(`XP_CLKS), "exit latency");
    check(cmd_ready, 1'b1, "ready after exit");
  endtask : wait_run

  // ==========================================================
  // Scenarios
  // Every bank address selects its mode register; the write strobe is one pulse.
  task automatic t_mrs();
    for (int b = 0; b < `NUM_BANKS; b++) begin
      model_u.send(4'h0, 1'b1, b[2:0], 14'h0000);
      check({mr_wr, mr_sel}, {1'b1, b[2:0]}, "mode register select");
      model_u.idle(1);
      check(mr_wr, 1'b0, "mode write pulse");
    end
    $display("test mode select done");
  endtask : t_mrs

  // Opens a row, decodes A10 on read and write, then active power-down and exit.
  task automatic t_active_pd();
    model_u.send(4'h3, 1'b1, 3'h3, 14'h1abc);
    model_u.idle(1);
    check(bank_open, 8'h08, "bank three open");
    model_u.send(4'h5, 1'b1, 3'h3, 14'h0400);
    check(auto_pre, 1'b1, "read auto-precharge bit");
    model_u.idle(model_u.RD_PRE_GAP);
    model_u.send(4'h4, 1'b1, 3'h3, 14'h0000);
    check(auto_pre, 1'b0, "write without auto-precharge");
    model_u.idle(model_u.WR_PRE_GAP);
    model_u.send(4'h7, 1'b0, 3'h0, 14'h0000);
    check(pstate, ddr2_cmd_pkg::ST_APD_FAST, "active power-down");
    check({pstate_slow, dll_slow}, {ddr2_cmd_pkg::ST_APD_SLOW, 1'b0}, "slow dll off");
    check({dll_on, bufs_on, cmd_ready}, 3'h4, "fast exit keeps dll");
    model_u.send(4'h3, 1'b0, 3'h5, 14'h0000);
    model_u.idle(2);
    check(bank_open, 8'h08, "command ignored in power-down");
    model_u.send(4'h7, 1'b1, 3'h0, 14'h0000);
    check(pstate, ddr2_cmd_pkg::ST_EXIT, "power-down exit");
    check(bufs_on, 1'b1, "buffers back on");
    wait_run();
    $display("test active power-down done");
  endtask : t_active_pd

  // Precharges back to back, then tries self refresh inside the precharge period.
  task automatic t_sref_busy();
    model_u.send(4'h2, 1'b1, 3'h3, 14'h0000);
    model_u.send(4'h2, 1'b1, 3'h0, 14'h0400);
    model_u.send(4'h1, 1'b0, 3'h0, 14'h0000);
    check(cmd_illegal, 1'b1, "self refresh while precharging");
    check(pstate, ddr2_cmd_pkg::ST_RUN, "no self refresh entry");
    do_reset();
    $display("test busy self refresh done");
  endtask : t_sref_busy

  // Precharge power-down with all banks idle, then self refresh and its exit.
  task automatic t_idle_modes();
    model_u.idle(2);
    // Entry by deselect, with bank and address bits left as junk.
    model_u.send(4'h8, 1'b0, 3'h2, 14'h2aaa);
    check(pstate, ddr2_cmd_pkg::ST_PPD, "precharge power-down");
    check({dll_on, bufs_on, cmd_ready}, 3'h0, "dll and buffers off");
    model_u.idle(3);
    model_u.send(4'h7, 1'b1, 3'h0, 14'h0000);
    check(pstate, ddr2_cmd_pkg::ST_EXIT, "precharge power-down exit");
    wait_run();
    // Reset the DLL by a mode register write once power-down is left.
    model_u.send(4'h0, 1'b1, 3'h0, 14'h0100);
    check({mr_wr, mr_sel}, 4'h8, "dll reset after exit");
    model_u.send(4'h1, 1'b1, 3'h0, 14'h0000);
    model_u.idle(8);
    model_u.send(4'h1, 1'b0, 3'h0, 14'h0000);
    check(pstate, ddr2_cmd_pkg::ST_SREF, "self refresh entry");
    check({dll_on, bufs_on, cmd_illegal}, 3'h0, "self refresh buffers off");
    model_u.send(4'h0, 1'b0, 3'h6, 14'h0000);
    model_u.idle(2);
    check({mr_wr, mr_sel}, 4'h0, "mode set ignored in self refresh");
    // Exit by deselect, with bank and address bits left as junk.
    model_u.send(4'hf, 1'b1, 3'h5, 14'h1555);
    check(pstate, ddr2_cmd_pkg::ST_EXIT, "self refresh exit");
    wait_run();
    $display("test idle power modes done");
  endtask : t_idle_modes

  // ==========================================================
  // Main sequence
  initial begin
    do_reset();
    t_mrs();
    t_active_pd();
    t_sref_busy();
    t_idle_modes();
    print_verdict();
  end
endmodule : ddr2_precharge_refresh_powerdown_tb_top
